// ===== src/spp_port.sv
// spp_port: one 16-pin parallel port with analog gating and change notification
// assumes an apb master on clk; pads resolve out/oe externally
`default_nettype none
module spp_port (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pads
  input wire logic [15:0] padIn,
  output spp_pkg::spp_pad_type pad,
  output logic [15:0] pullupEn,
  // change-notification pins and request
  input wire logic [23:0] chgIn,
  output logic chgReq,
  output logic chgWake,
  // shared peripherals
  input wire spp_pkg::spp_periph_type periph,
  output logic [15:0] periphIn
);
  logic [15:0] dir_r, lat_r, odc_r, an1_r, an2_r;
  logic [23:0] cie_r, cpu_r, pend_r, pend_nxt, prev_r;
  logic [15:0] s1_r, s2_r, s3_r, pinSync_r;
  logic [23:0] c1_r, c2_r, c3_r, chgSync_r;
  logic [23:0] prevRaw_r;
  logic [15:0] analog, portDrive, drvVal, drvOe, pinRead;
  logic wrEn, rdEn, hit;
  logic [15:0] wd16;
  logic [23:0] diff, clrMask;
  logic [31:0] rdMux;
  logic [15:0] ownMask;
  logic wrDir, wrLat, wrOdc, wrAn1, wrAn2, wrCie, wrCpu, wrCpd;

  // apb decode: zero-wait slave, errors on unmapped offsets
  assign wrEn = psel & penable & pwrite;
  assign rdEn = psel & ~pwrite;
  assign wd16 = pwdata[15:0] & spp_pkg::IMPL_MASK;
  assign hit = paddr inside {spp_pkg::OFF_DIR, spp_pkg::OFF_PIN, spp_pkg::OFF_LAT,
    spp_pkg::OFF_ODC, spp_pkg::OFF_AN1, spp_pkg::OFF_AN2, spp_pkg::OFF_CIE,
    spp_pkg::OFF_CPU, spp_pkg::OFF_CPD};
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // analog if either converter clears its select bit
  assign analog = ~(an1_r & an2_r) & spp_pkg::ANALOG_CAPABLE;

  // one strobe per register so each register block below stays short
  assign wrDir = wrEn && (paddr == spp_pkg::OFF_DIR);
  // both latch and pin offsets write the latch
  assign wrLat = wrEn && (paddr == spp_pkg::OFF_LAT || paddr == spp_pkg::OFF_PIN);
  assign wrOdc = wrEn && (paddr == spp_pkg::OFF_ODC);
  assign wrAn1 = wrEn && (paddr == spp_pkg::OFF_AN1);
  assign wrAn2 = wrEn && (paddr == spp_pkg::OFF_AN2);
  assign wrCie = wrEn && (paddr == spp_pkg::OFF_CIE);
  assign wrCpu = wrEn && (paddr == spp_pkg::OFF_CPU);
  assign wrCpd = wrEn && (paddr == spp_pkg::OFF_CPD);

  // direction; every reset makes all pins inputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dir_r <= spp_pkg::RST_DIR;
    end else if (wrDir) begin
      dir_r <= wd16 | ~spp_pkg::IMPL_MASK;
    end
  end

  // output latch, written from either the latch or the pin offset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lat_r <= spp_pkg::RST_LAT;
    end else if (wrLat) begin
      lat_r <= wd16;
    end
  end

  // open-drain selects
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      odc_r <= spp_pkg::RST_ODC;
    end else if (wrOdc) begin
      odc_r <= wd16;
    end
  end

  // first converter's analog selects; pins without analog use stay digital
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      an1_r <= spp_pkg::RST_AN;
    end else if (wrAn1) begin
      an1_r <= pwdata[15:0] | ~spp_pkg::ANALOG_CAPABLE;
    end
  end

  // second converter's analog selects
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      an2_r <= spp_pkg::RST_AN;
    end else if (wrAn2) begin
      an2_r <= pwdata[15:0] | ~spp_pkg::ANALOG_CAPABLE;
    end
  end

  // change-interrupt enables, one per change input
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cie_r <= spp_pkg::RST_CHG;
    end else if (wrCie) begin
      cie_r <= pwdata[23:0];
    end
  end

  // weak pull-up enables
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_r <= spp_pkg::RST_CHG;
    end else if (wrCpu) begin
      cpu_r <= pwdata[23:0];
    end
  end

  // three-stage synchronisers; a change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 16'h0000;
      s2_r <= 16'h0000;
      s3_r <= 16'h0000;
      pinSync_r <= 16'h0000;
      c1_r <= 24'h000000;
      c2_r <= 24'h000000;
      c3_r <= 24'h000000;
      chgSync_r <= 24'h000000;
    end else begin
      s1_r <= padIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pinSync_r <= (s2_r == s3_r) ? s3_r : pinSync_r;
      c1_r <= chgIn;
      c2_r <= c1_r;
      c3_r <= c2_r;
      // take stage three only where it agrees with stage two, else hold
      chgSync_r <= (~(c2_r ^ c3_r) & c3_r) | ((c2_r ^ c3_r) & chgSync_r);
    end
  end

  // output ownership: active peripheral wins, otherwise the port by direction
  assign ownMask = periph.enable & periph.drive;
  assign portDrive = ~dir_r & ~ownMask & spp_pkg::IMPL_MASK;
  // per-bit select: a whole-vector choice would hand every pin to the peripherals
  assign drvVal = (ownMask & periph.value) | (~ownMask & lat_r);
  // open drain: a high value releases the pin instead of driving it
  assign drvOe = (portDrive | (periph.enable & periph.drive)) & ~(odc_r & drvVal);
  assign pad.out = drvVal & ~odc_r;
  assign pad.oe = drvOe;
  // peripheral input only from the pin, zero while the port itself drives it
  assign periphIn = pinSync_r & ~portDrive & ~analog;
  assign pinRead = pinSync_r & ~analog & spp_pkg::IMPL_MASK;
  assign pullupEn = cpu_r[15:0] & spp_pkg::IMPL_MASK;

  // change detect on captured levels; pending stays until written one to clear
  assign diff = (chgSync_r ^ prev_r) & cie_r;
  assign clrMask = (wrEn && paddr == spp_pkg::OFF_CPD) ? pwdata[23:0] : 24'h000000;
  assign pend_nxt = (pend_r & ~clrMask) | diff; // set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_r <= 24'h000000;
      pend_r <= 24'h000000;
      prevRaw_r <= 24'h000000;
    end else begin
      prev_r <= chgSync_r;
      pend_r <= pend_nxt;
      prevRaw_r <= chgSync_r;
    end
  end
  assign chgReq = |pend_r;
  // clockless wake path: raw pin against last captured level, no clock needed
  assign chgWake = |((chgIn ^ prevRaw_r) & cie_r);

  // read mux, registered-free for a zero-wait answer
  always_comb begin
    rdMux = 32'h00000000;
    unique case (paddr)
      spp_pkg::OFF_DIR: rdMux = {16'h0000, dir_r & spp_pkg::IMPL_MASK};
      spp_pkg::OFF_PIN: rdMux = {16'h0000, pinRead};
      spp_pkg::OFF_LAT: rdMux = {16'h0000, lat_r};
      spp_pkg::OFF_ODC: rdMux = {16'h0000, odc_r};
      spp_pkg::OFF_AN1: rdMux = {16'h0000, an1_r};
      spp_pkg::OFF_AN2: rdMux = {16'h0000, an2_r};
      spp_pkg::OFF_CIE: rdMux = {8'h00, cie_r};
      spp_pkg::OFF_CPU: rdMux = {8'h00, cpu_r};
      spp_pkg::OFF_CPD: rdMux = {8'h00, pend_r};
      default: rdMux = 32'h00000000;
    endcase
  end
  assign prdata = rdEn ? rdMux : 32'h00000000;

  // assertions
  dir_reset_a: assert property (@(posedge clk) $rose(rst_b) |-> dir_r == 16'hFFFF)
    else $error("direction not all inputs after reset");
  periph_owns_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((periph.enable & periph.drive & ~dir_r) != 0) |-> ((portDrive & periph.enable & periph.drive) == 0))
    else $error("port drives a pin owned by a peripheral");
  port_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    (periph.enable[0] && !periph.drive[0] && !dir_r[0]) |-> portDrive[0])
    else $error("port not driving idle peripheral pin");
  no_loop_a: assert property (@(posedge clk) disable iff (!rst_b)
    (periphIn & portDrive) == 0)
    else $error("port output loops into peripheral");
  pin_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    (wrEn && paddr == spp_pkg::OFF_PIN) |=> lat_r == $past(wd16))
    else $error("pin register write missed latch");
  od_high_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((odc_r & drvVal & pad.oe) == 0))
    else $error("open drain drives high");
  analog_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    (rdEn && paddr == spp_pkg::OFF_PIN) |-> ((prdata[15:0] & analog) == 0))
    else $error("analog pin reads nonzero");
  chg_pend_a: assert property (@(posedge clk) disable iff (!rst_b)
    (diff != 0) |=> chgReq [*2])
    else $error("change request not held");
  sync_three_a: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(pinSync_r) |-> $past(s2_r) == $past(s3_r))
    else $error("pin read changed before stages agreed");

  // named steps of the register and change-notification behaviours
  sequence latWriteSeq;
    wrEn && (paddr == spp_pkg::OFF_LAT);
  endsequence
  sequence dirWriteSeq;
    wrDir;
  endsequence
  sequence clearOnlySeq;
    wrCpd && (diff == 24'h000000);
  endsequence
  sequence quietSeq;
    !chgReq && (diff == 24'h000000);
  endsequence

  // register writes land one edge later
  lat_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    latWriteSeq |=> lat_r == $past(wd16))
    else $error("latch write missed");
  dir_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    dirWriteSeq |=> dir_r == $past(wd16 | ~spp_pkg::IMPL_MASK))
    else $error("direction write missed");
  pullup_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    wrCpu |=> pullupEn == $past(pwdata[15:0] & spp_pkg::IMPL_MASK))
    else $error("pull-up enable write missed");
  cie_write_a: assert property (@(posedge clk) disable iff (!rst_b)
    wrCie |=> cie_r == $past(pwdata[23:0]))
    else $error("change enable write missed");

  // read paths
  lat_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (rdEn && paddr == spp_pkg::OFF_LAT) |-> prdata[15:0] == lat_r)
    else $error("latch read wrong");
  pin_upper_a: assert property (@(posedge clk) disable iff (!rst_b)
    (rdEn && paddr == spp_pkg::OFF_PIN) |-> prdata[31:16] == 16'h0000)
    else $error("pin read upper bits set");
  pend_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (rdEn && paddr == spp_pkg::OFF_CPD) |-> prdata[23:0] == pend_r)
    else $error("pending read wrong");
  owned_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ownMask & ~analog & (pinRead ^ pinSync_r)) == 16'h0000)
    else $error("peripheral pin not readable");

  // reset state and analog selection
  an_reset_a: assert property (@(posedge clk)
    $rose(rst_b) |-> ((an1_r | an2_r) & spp_pkg::ANALOG_CAPABLE) == 16'h0000)
    else $error("analog pins not analog after reset");
  reset_release_a: assert property (@(posedge clk)
    $rose(rst_b) |-> (pad.oe & ~ownMask) == 16'h0000)
    else $error("port drives a pin after reset");
  analog_either_a: assert property (@(posedge clk) disable iff (!rst_b)
    ((~an1_r | ~an2_r) & spp_pkg::ANALOG_CAPABLE & ~analog) == 16'h0000)
    else $error("cleared select bit not analog");

  // pad drive ownership and open drain
  od_low_a: assert property (@(posedge clk) disable iff (!rst_b)
    (odc_r & pad.out) == 16'h0000)
    else $error("open drain pad drives high");
  unimpl_oe_a: assert property (@(posedge clk) disable iff (!rst_b)
    (pad.oe & ~spp_pkg::IMPL_MASK) == 16'h0000)
    else $error("unimplemented pin driven");
  port_in_a: assert property (@(posedge clk) disable iff (!rst_b)
    (dir_r & ~ownMask & pad.oe) == 16'h0000)
    else $error("input pin driven by port");
  periph_value_a: assert property (@(posedge clk) disable iff (!rst_b)
    (ownMask & ~odc_r & (pad.out ^ periph.value)) == 16'h0000)
    else $error("owned pin not at peripheral value");
  lat_value_a: assert property (@(posedge clk) disable iff (!rst_b)
    (portDrive & ~odc_r & (pad.out ^ lat_r)) == 16'h0000)
    else $error("port pin not at latch value");

  // synchronisers hold until stages two and three agree
  sync_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (s2_r != s3_r) |=> $stable(pinSync_r))
    else $error("pin level moved while stages disagree");
  chg_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    (c2_r != c3_r) |=> $stable(chgSync_r))
    else $error("change level moved while stages disagree");
  chg_follow_a: assert property (@(posedge clk) disable iff (!rst_b)
    (c2_r == c3_r) |=> chgSync_r == $past(c3_r))
    else $error("change level missed agreed stages");

  // pending requests: kept until cleared, cleared when asked, none from nothing
  pend_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    (chgReq && !wrCpd) |=> chgReq)
    else $error("pending request lost");
  pend_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    clearOnlySeq |=> (pend_r & $past(clrMask)) == 24'h000000)
    else $error("pending bit not cleared");
  chg_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
    quietSeq |=> !chgReq)
    else $error("request without a change");
  wake_idle_a: assert property (@(posedge clk) disable iff (!rst_b)
    (cie_r == 24'h000000) |-> !chgWake)
    else $error("wake without enabled input");
endmodule
`default_nettype wire

// ===== src/spp_pkg.sv
// spp_pkg: constants, register map and carrier types for the shared-pin parallel port
// assumes a 32-bit apb slave, 16 pins per port and 24 change-notification inputs
package spp_pkg;
  localparam int PINS = 16;
  localparam int CHG_PINS = 24;
  localparam logic [PINS-1:0] IMPL_MASK = 16'hFFFF;
  localparam logic [PINS-1:0] ANALOG_CAPABLE = 16'hFFFF;
  // register byte offsets
  localparam logic [5:0] OFF_DIR = 6'h00;
  localparam logic [5:0] OFF_PIN = 6'h04;
  localparam logic [5:0] OFF_LAT = 6'h08;
  localparam logic [5:0] OFF_ODC = 6'h0C;
  localparam logic [5:0] OFF_AN1 = 6'h10;
  localparam logic [5:0] OFF_AN2 = 6'h14;
  localparam logic [5:0] OFF_CIE = 6'h18;
  localparam logic [5:0] OFF_CPU = 6'h1C;
  localparam logic [5:0] OFF_CPD = 6'h20;
  // reset values
  localparam logic [PINS-1:0] RST_DIR = 16'hFFFF;
  localparam logic [PINS-1:0] RST_LAT = 16'h0000;
  localparam logic [PINS-1:0] RST_ODC = 16'h0000;
  localparam logic [PINS-1:0] RST_AN = ~ANALOG_CAPABLE;
  localparam logic [CHG_PINS-1:0] RST_CHG = 24'h000000;
  // peripheral side of each pin
  typedef struct packed {
    logic [PINS-1:0] enable;
    logic [PINS-1:0] drive;
    logic [PINS-1:0] value;
  } spp_periph_type;
  // pad side of each pin
  typedef struct packed {
    logic [PINS-1:0] out;
    logic [PINS-1:0] oe;
  } spp_pad_type;
endpackage

// ===== verification/spp_pad_model.sv
// spp_pad_model: pads and the outside world as the port sees them
// assumes the outside level only shows on pads that the port releases
`default_nettype none
module spp_pad_model (
  // pad drive from the port
  input wire spp_pkg::spp_pad_type pad,
  // outside level and resolved pad level
  input wire logic [15:0] ext,
  output logic [15:0] padIn
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released open-drain pad shows the outside level, never a stale high
  assign padIn = (pad.oe & pad.out) | (~pad.oe & ext);
endmodule
`default_nettype wire

// ===== verification/test_spp_port.sv
// test_spp_port: self-checking bench for the shared-pin parallel port
// assumes spp_pad_model resolves pads; reads are checked from a queue of notes
`default_nettype none
module test_spp_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, chgReq, chgWake;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h00000000, prdata;
  logic [15:0] padIn, pullupEn, periphIn, v, ext = 16'h0000;
  logic [23:0] chgIn = 24'h000000;
  spp_pkg::spp_pad_type pad;
  spp_pkg::spp_periph_type periph = '0;
  logic [32:0] q[$];
  int fails = 0, n_compared = 0, cyc = 0;
  always #5 clk = ~clk;
  spp_port dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .padIn(padIn), .pad(pad), .pullupEn(pullupEn), .chgIn(chgIn), .chgReq(chgReq),
    .chgWake(chgWake), .periph(periph), .periphIn(periphIn));
  spp_pad_model pm (.pad(pad), .ext(ext), .padIn(padIn));
  // one compare for every result, counted
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // hang guard, far above the roughly 130 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      tally_and_finish();
    end
  end
  // read watcher: error flag and data taken at the completing edge
  always @(posedge clk)
    if (psel && penable && !pwrite && pready === 1'b1) cmp({pslverr, prdata}, q.pop_front());
  // apb transfer; the extra edge at the end keeps psel from two drives in one step
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [32:0] exp);
    q.push_back(exp);
    xfer(1'b0, a, 32'h00000000);
  endtask
  initial begin
    void'($urandom(67668));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(spp_pkg::OFF_DIR, {17'h00000, spp_pkg::RST_DIR});
    rd(spp_pkg::OFF_AN1, 33'h000000000);
    ext <= 16'hFFFF;
    repeat (6) @(posedge clk);
    rd(spp_pkg::OFF_PIN, 33'h000000000);
    rd(6'h24, 33'h100000000);
    xfer(1'b1, spp_pkg::OFF_LAT, 32'hFFFFFFFF);
    rd(spp_pkg::OFF_LAT, 33'h00000FFFF);
    // upper pins stay analog while either converter keeps them cleared
    xfer(1'b1, spp_pkg::OFF_AN1, 32'h0000FFFF);
    xfer(1'b1, spp_pkg::OFF_AN2, 32'h000000FF);
    v = 16'($urandom());
    ext <= v;
    repeat (6) @(posedge clk);
    rd(spp_pkg::OFF_PIN, {17'h00000, v & 16'h00FF});
    xfer(1'b1, spp_pkg::OFF_AN2, 32'h0000FFFF);
    // latch written through the pin register, then all pins made outputs
    v = 16'($urandom());
    xfer(1'b1, spp_pkg::OFF_PIN, {16'h0000, v});
    rd(spp_pkg::OFF_LAT, {17'h00000, v});
    xfer(1'b1, spp_pkg::OFF_DIR, 32'h00000000);
    cmp({1'b0, pad.oe, pad.out}, {17'h0FFFF, v});
    repeat (6) @(posedge clk);
    rd(spp_pkg::OFF_PIN, {17'h00000, v});
    xfer(1'b1, spp_pkg::OFF_ODC, 32'h0000FFFF);
    cmp({1'b0, pad.oe, pad.out & pad.oe}, {1'b0, ~v, 16'h0000});
    xfer(1'b1, spp_pkg::OFF_ODC, 32'h00000000);
    // pull-ups written and checked while the pins are inputs
    xfer(1'b1, spp_pkg::OFF_DIR, 32'h0000FFFF);
    xfer(1'b1, spp_pkg::OFF_CPU, {8'h00, 8'h5A, v});
    cmp({17'h00000, pullupEn}, {17'h00000, v});
    xfer(1'b1, spp_pkg::OFF_CPU, 32'h00000000);
    xfer(1'b1, spp_pkg::OFF_DIR, 32'h00000000);
    // peripheral drives the upper byte, idle on the lower byte
    periph <= {16'hFFFF, 16'hFF00, 16'hA5A5};
    @(posedge clk);
    cmp({1'b0, pad.oe, pad.out}, {17'h0FFFF, 8'hA5, v[7:0]});
    repeat (6) @(posedge clk);
    cmp({17'h00000, periphIn}, {17'h00000, 8'hA5, 8'h00});
    // change notification: a disabled input is ignored, bit 23 raises it
    xfer(1'b1, spp_pkg::OFF_CIE, 32'h00800000);
    chgIn <= 24'h000001;
    repeat (6) @(posedge clk);
    cmp({32'h00000000, chgReq}, 33'h000000000);
    chgIn <= 24'h800001;
    repeat (6) @(posedge clk);
    cmp({32'h00000000, chgReq}, 33'h000000001);
    chgIn <= 24'h000001;
    #1;
    cmp({32'h00000000, chgWake}, 33'h000000001);
    repeat (6) @(posedge clk);
    rd(spp_pkg::OFF_CPD, {9'h000, 24'h800000});
    xfer(1'b1, spp_pkg::OFF_CPD, 32'h00800000);
    cmp({32'h00000000, chgReq}, 33'h000000000);
    repeat (3) @(posedge clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
